/* pld_power_pkg.sv */
// Constants and carrier types for the logic-module power control block
package pld_power_pkg;

  // Register selects on the host control port
  localparam logic [1:0] SEL_REG_A = 2'h0;
  localparam logic [1:0] SEL_REG_B = 2'h1;
  localparam logic [1:0] SEL_REG_C = 2'h2;

  // Field positions
  localparam int AUTO_SLEEP_EN_BIT = 1;
  localparam int TURBO_OFF_BIT = 3;
  localparam int CLK_BUS_BLOCK_BIT = 4;
  localparam int CLK_OMC_BLOCK_BIT = 5;
  localparam int WR_BLOCK_BIT = 2;
  localparam int RD_BLOCK_BIT = 3;
  localparam int PROGRAM_STORE_ENABLE_N_BLOCK_BIT = 4;
  localparam int ALE_BLOCK_BIT = 5;
  localparam int PC7_BLOCK_BIT = 6;
  localparam int FORCE_SLEEP_BIT = 1;

  // Writable bit masks; unused bits read zero
  localparam logic [7:0] REG_A_MASK = 8'h3A;
  localparam logic [7:0] REG_B_MASK = 8'h7C;
  localparam logic [7:0] REG_C_MASK = 8'h02;

  // Reset values
  localparam logic [7:0] REG_A_RESET = 8'h00;
  localparam logic [7:0] REG_B_RESET = 8'h00;

  // Idle counter terminal count in shared clock periods
  localparam logic [3:0] IDLE_COUNT_MAX = 4'hF;

  // Array idle time before standby
  localparam int CLK_PERIOD_NS = 10;
  localparam int IDLE_5V_NS = 65;
  localparam int IDLE_3V3_NS = 100;
  localparam int IDLE_5V_CYCLES = (IDLE_5V_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_3V3_CYCLES = (IDLE_3V3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STANDBY_CNT_W = 4;

  localparam int ARRAY_OUT_W = 16;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic program_store_enable_n_n;
    logic ale;
  } strobe_type;

  typedef struct packed {
    logic wr_n;
    logic rd_n;
    logic program_store_enable_n_n;
    logic ale;
    logic port_c_bit7;
    logic shared_clk;
    logic sleep_indicator;
  } logic_bus_type;

  typedef struct packed {
    logic flash;
    logic boot;
    logic sram;
    logic ctrl;
  } mem_sel_type;

endpackage

/* pld_module_power_control.sv */
// Power-down, chip-select, non-turbo standby and input blocking for the logic module
`timescale 1ns/1ns
module pld_module_power_control (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic warm_reset_n_i,
  input wire logic supply_3v3_i,
  input wire logic chip_select_enable_i,
  input wire logic chip_select_n_i,
  input wire logic port_c_bit7_i,
  input wire logic shared_logic_clock_i,
  input wire pld_power_pkg::strobe_type strobe_i,
  input wire logic [pld_power_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pld_power_pkg::DATA_W-1:0] data_i,
  input wire pld_power_pkg::mem_sel_type mem_sel_i,
  input wire logic [pld_power_pkg::ARRAY_OUT_W-1:0] array_result_i,
  input wire logic reg_write_i,
  input wire logic [1:0] reg_select_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] power_control_reg_a_o,
  output logic [7:0] power_control_reg_b_o,
  output logic [7:0] power_control_reg_c_o,
  output logic sleep_indicator_o,
  output logic code_mem_avail_o,
  output pld_power_pkg::strobe_type mem_strobe_o,
  output pld_power_pkg::mem_sel_type mem_sel_o,
  output logic [pld_power_pkg::ADDR_W-1:0] addr_o,
  output logic [pld_power_pkg::DATA_W-1:0] data_o,
  output pld_power_pkg::logic_bus_type logic_bus_o,
  output logic omc_clock_en_o,
  output logic array_standby_o,
  output logic [pld_power_pkg::ARRAY_OUT_W-1:0] array_out_o
);

  typedef enum logic {AWAKE, ASLEEP} sleep_state_type;

  // Two-stage synchronisers for pin inputs
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic wreset_n;
  logic cs_n;
  logic pc7;
  logic sclk;
  logic sclk_d;
  logic wreset_n_d;
  logic cs_n_d;
  logic ale_d;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 4'hF;
      sync_b <= 4'hF;
    end else if (clk_en_i) begin
      sync_a <= {warm_reset_n_i, chip_select_n_i, port_c_bit7_i, shared_logic_clock_i};
      sync_b <= sync_a;
    end
  end

  assign wreset_n = sync_b[3];
  assign cs_n = sync_b[2];
  assign pc7 = sync_b[1];
  assign sclk = sync_b[0];

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_d <= 1'b1;
      wreset_n_d <= 1'b1;
      cs_n_d <= 1'b1;
      ale_d <= 1'b0;
    end else if (clk_en_i) begin
      sclk_d <= sclk;
      wreset_n_d <= wreset_n;
      cs_n_d <= cs_n;
      ale_d <= strobe_i.ale;
    end
  end

  wire sclk_rise = sclk & ~sclk_d;
  wire warm_rise = wreset_n & ~wreset_n_d;
  wire warm_active = ~wreset_n;
  wire ale_toggle = strobe_i.ale ^ ale_d;
  wire cs_fall = chip_select_enable_i & cs_n_d & ~cs_n;

  // Power control registers
  logic [7:0] power_control_reg_a;
  logic [7:0] power_control_reg_b;
  logic force_sleep_bit;

  wire wr_a = reg_write_i & (reg_select_i == pld_power_pkg::SEL_REG_A);
  wire wr_b = reg_write_i & (reg_select_i == pld_power_pkg::SEL_REG_B);
  wire wr_c = reg_write_i & (reg_select_i == pld_power_pkg::SEL_REG_C);
  wire force_write = wr_c & reg_wdata_i[pld_power_pkg::FORCE_SLEEP_BIT];

  wire [7:0] next_reg_a_written = reg_wdata_i & pld_power_pkg::REG_A_MASK;
  // Warm reset keeps reg A except the turbo bit, which returns to turbo on
  wire [7:0] turbo_clear_mask = ~(8'h01 << pld_power_pkg::TURBO_OFF_BIT);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_control_reg_a <= pld_power_pkg::REG_A_RESET;
    end else if (clk_en_i) begin
      if (warm_active) begin
        power_control_reg_a <= power_control_reg_a & turbo_clear_mask;
      end else if (wr_a) begin
        power_control_reg_a <= next_reg_a_written;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_control_reg_b <= pld_power_pkg::REG_B_RESET;
    end else if (clk_en_i && wr_b) begin
      power_control_reg_b <= reg_wdata_i & pld_power_pkg::REG_B_MASK;
    end
  end

  // Sticky: a zero write never clears it, only reset or a warm reset does
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      force_sleep_bit <= 1'b0;
    end else if (clk_en_i) begin
      if (warm_active) begin
        force_sleep_bit <= 1'b0;
      end else if (force_write) begin
        force_sleep_bit <= 1'b1;
      end
    end
  end

  wire auto_sleep_en = power_control_reg_a[pld_power_pkg::AUTO_SLEEP_EN_BIT];
  wire turbo_off = power_control_reg_a[pld_power_pkg::TURBO_OFF_BIT];
  wire clk_bus_block = power_control_reg_a[pld_power_pkg::CLK_BUS_BLOCK_BIT];
  wire clk_omc_block = power_control_reg_a[pld_power_pkg::CLK_OMC_BLOCK_BIT];
  wire [7:0] reg_c_view = {6'h00, force_sleep_bit, 1'b0};

  assign power_control_reg_a_o = power_control_reg_a;
  assign power_control_reg_b_o = power_control_reg_b;
  assign power_control_reg_c_o = reg_c_view;

  wire [7:0] next_rdata = (reg_select_i == pld_power_pkg::SEL_REG_A) ? power_control_reg_a :
                          (reg_select_i == pld_power_pkg::SEL_REG_B) ? power_control_reg_b :
                          (reg_select_i == pld_power_pkg::SEL_REG_C) ? reg_c_view : 8'h00;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Idle counter, advanced by rising shared clock edges while ALE is steady
  logic [3:0] idle_count;
  wire idle_done = (idle_count == pld_power_pkg::IDLE_COUNT_MAX);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_count <= 4'h0;
    end else if (clk_en_i) begin
      if (warm_active || !auto_sleep_en || ale_toggle) begin
        idle_count <= 4'h0;
      end else if (sclk_rise && !idle_done) begin
        idle_count <= idle_count + 4'h1;
      end
    end
  end

  // Forced entry bypasses the counter entirely, so no shared clock is needed
  wire enter_forced = force_write | force_sleep_bit;
  // The indicator rises once the count has reached its top, so no sixteenth clock edge is needed
  wire enter_auto = auto_sleep_en & idle_done & ~ale_toggle;
  wire wake_event = ale_toggle | cs_fall | warm_rise;

  sleep_state_type sleep_state;
  sleep_state_type next_sleep_state;
  logic force_seen;

  // A held force bit re-enters sleep only after a fresh write, so a wake still takes effect
  wire force_fresh = force_write | (force_sleep_bit & ~force_seen);

  always_comb begin
    next_sleep_state = sleep_state;
    unique case (sleep_state)
      AWAKE: begin
        if (!warm_active && (force_fresh || enter_auto)) begin
          next_sleep_state = ASLEEP;
        end
      end
      ASLEEP: begin
        if (warm_active || wake_event) begin
          next_sleep_state = AWAKE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_state <= AWAKE;
      force_seen <= 1'b0;
    end else if (clk_en_i) begin
      sleep_state <= next_sleep_state;
      force_seen <= force_sleep_bit & ~warm_active;
    end
  end

  // Immediate view so the entering write already takes code memory away
  wire asleep = (sleep_state == ASLEEP) | (force_write & ~warm_active) | (enter_forced & force_fresh);
  wire unused_enter = enter_forced;

  assign sleep_indicator_o = (sleep_state == ASLEEP);
  assign code_mem_avail_o = ~asleep;

  // Memory select gating by chip-select and sleep
  wire cs_allows = ~chip_select_enable_i | ~cs_n;
  wire sel_ok = cs_allows & ~asleep;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_sel_o <= '0;
      addr_o <= '0;
      data_o <= '0;
      mem_strobe_o <= '{wr_n: 1'b1, rd_n: 1'b1, program_store_enable_n_n: 1'b1, ale: 1'b0};
    end else if (clk_en_i) begin
      mem_sel_o <= sel_ok ? mem_sel_i : '0;
      if (!asleep) begin
        addr_o <= addr_i;
        data_o <= data_i;
      end
      mem_strobe_o <= strobe_i;
    end
  end

  // Logic input bus with per-signal blocking
  pld_power_pkg::logic_bus_type next_bus;
  always_comb begin
    next_bus.wr_n = strobe_i.wr_n | power_control_reg_b[pld_power_pkg::WR_BLOCK_BIT];
    next_bus.rd_n = strobe_i.rd_n | power_control_reg_b[pld_power_pkg::RD_BLOCK_BIT];
    next_bus.program_store_enable_n_n = strobe_i.program_store_enable_n_n | power_control_reg_b[pld_power_pkg::PROGRAM_STORE_ENABLE_N_BLOCK_BIT];
    next_bus.ale = strobe_i.ale & ~power_control_reg_b[pld_power_pkg::ALE_BLOCK_BIT];
    next_bus.port_c_bit7 = pc7 & ~power_control_reg_b[pld_power_pkg::PC7_BLOCK_BIT];
    next_bus.shared_clk = sclk & ~clk_bus_block;
    next_bus.sleep_indicator = (sleep_state == ASLEEP);
  end

  // Blocked inputs park at their idle level, so they cause no transitions
  wire bus_changed = (next_bus != logic_bus_o);
  logic [pld_power_pkg::ADDR_W-1:0] addr_seen;
  wire addr_changed = ~asleep & (addr_i != addr_seen);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      logic_bus_o <= '{wr_n: 1'b1, rd_n: 1'b1, program_store_enable_n_n: 1'b1, ale: 1'b0, port_c_bit7: 1'b0,
                       shared_clk: 1'b0, sleep_indicator: 1'b0};
      addr_seen <= '0;
      omc_clock_en_o <= 1'b0;
    end else if (clk_en_i) begin
      logic_bus_o <= next_bus;
      if (!asleep) begin
        addr_seen <= addr_i;
      end
      omc_clock_en_o <= sclk_rise & ~clk_omc_block;
    end
  end

  // Non-turbo standby after a quiet stretch on all array inputs
  localparam logic [pld_power_pkg::STANDBY_CNT_W-1:0] IDLE_5V =
    pld_power_pkg::STANDBY_CNT_W'(pld_power_pkg::IDLE_5V_CYCLES);
  localparam logic [pld_power_pkg::STANDBY_CNT_W-1:0] IDLE_3V3 =
    pld_power_pkg::STANDBY_CNT_W'(pld_power_pkg::IDLE_3V3_CYCLES);

  logic [pld_power_pkg::STANDBY_CNT_W-1:0] quiet_count;
  wire [pld_power_pkg::STANDBY_CNT_W-1:0] quiet_limit = supply_3v3_i ? IDLE_3V3 : IDLE_5V;
  wire array_activity = bus_changed | addr_changed;
  wire quiet_reached = (quiet_count >= quiet_limit);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_count <= '0;
      array_standby_o <= 1'b0;
    end else if (clk_en_i) begin
      if (!turbo_off || array_activity) begin
        quiet_count <= '0;
        array_standby_o <= 1'b0;
      end else begin
        if (!quiet_reached) begin
          quiet_count <= quiet_count + 1'b1;
        end
        array_standby_o <= quiet_reached;
      end
    end
  end

  // Chip-select has no say here: array outputs only follow standby
  wire enter_standby = turbo_off & ~array_activity & quiet_reached & ~array_standby_o;
  wire hold_outputs = (array_standby_o & ~array_activity) | enter_standby;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      array_out_o <= '0;
    end else if (clk_en_i) begin
      if (!hold_outputs) begin
        array_out_o <= array_result_i;
      end
    end
  end

endmodule

/* pld_power_properties.sv */
// Concurrent checks on the ports of the power control block
`timescale 1ns/1ns
module pld_power_properties (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic warm_reset_n_i,
  input wire logic chip_select_enable_i,
  input wire logic chip_select_n_i,
  input wire pld_power_pkg::strobe_type strobe_i,
  input wire logic reg_write_i,
  input wire logic [1:0] reg_select_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] power_control_reg_a_o,
  input wire logic [7:0] power_control_reg_b_o,
  input wire logic [7:0] power_control_reg_c_o,
  input wire logic sleep_indicator_o,
  input wire logic code_mem_avail_o,
  input wire pld_power_pkg::strobe_type mem_strobe_o,
  input wire pld_power_pkg::mem_sel_type mem_sel_o,
  input wire logic [pld_power_pkg::ADDR_W-1:0] addr_o,
  input wire pld_power_pkg::logic_bus_type logic_bus_o,
  input wire logic omc_clock_en_o,
  input wire logic array_standby_o,
  input wire logic [pld_power_pkg::ARRAY_OUT_W-1:0] array_out_o
);
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Warm reset passes a two-stage synchroniser, so it must be quiet a while
  sequence warm_quiet;
    warm_reset_n_i [*3];
  endsequence
  sequence force_wr;
    clk_en_i && reg_write_i && reg_select_i == pld_power_pkg::SEL_REG_C && reg_wdata_i[1];
  endsequence
  a_force_sleep_now: assert property (warm_quiet ##0 force_wr |=> sleep_indicator_o)
    else $error("no sleep after force write");
  a_code_mem_off: assert property (force_wr |-> !code_mem_avail_o)
    else $error("code memory on at force write");
  a_force_bit_sticky: assert property (warm_quiet ##0 power_control_reg_c_o[1] |=> power_control_reg_c_o[1])
    else $error("force bit cleared");
  a_cs_high_none: assert property ((chip_select_enable_i && chip_select_n_i) [*4] |=> mem_sel_o == 4'h0)
    else $error("memory selected with cs high");
  a_strobes_blocked: assert property ((power_control_reg_b_o[5:2] == 4'hF) [*2] |->
    logic_bus_o.wr_n && logic_bus_o.rd_n && logic_bus_o.program_store_enable_n_n && !logic_bus_o.ale)
    else $error("blocked strobe on logic bus");
  a_omc_clock_blocked: assert property (power_control_reg_a_o[5] [*2] |-> !omc_clock_en_o)
    else $error("macrocell clock while blocked");
  a_direct_strobes: assert property (clk_en_i |=> mem_strobe_o == $past(strobe_i))
    else $error("memory strobe mismatch");
  a_ale_wake: assert property (sleep_indicator_o && $changed(strobe_i.ale) && clk_en_i && !reg_write_i
    |=> !sleep_indicator_o)
    else $error("no wake on address latch");
  a_sleep_blocks_bus: assert property (sleep_indicator_o [*2] |-> $stable(addr_o) && mem_sel_o == 4'h0)
    else $error("bus passes while asleep");
  a_standby_hold: assert property (array_standby_o && $past(array_standby_o) |-> $stable(array_out_o))
    else $error("array output moved in standby");
endmodule

/* host_bus_model.sv */
// Behavioural host bus driving strobes and address into the block
`timescale 1ns/1ns
module host_bus_model (
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic turbo_off_i,
  output pld_power_pkg::strobe_type strobe_o,
  output logic [pld_power_pkg::ADDR_W-1:0] addr_o
);
  logic slot = 1'b0;
  // A parked host holds every strobe still so nothing wakes the module
  initial begin
    strobe_o = 4'hE;
    addr_o = 16'h0000;
  end
  always @(posedge ref_clk_i) begin
    slot <= ~slot;
    // Turbo off costs one extra wait state per bus cycle
    if (run_i && (!turbo_off_i || slot)) begin
      strobe_o.ale <= ~strobe_o.ale;
      strobe_o.rd_n <= strobe_o.ale;
      addr_o <= addr_o + 16'h0001;
    end
  end
endmodule

/* tb.sv */
// Self-checking bench for the logic-module power control block
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic warm_n = 1'b1;
  logic supply = 1'b0;
  logic cs_en = 1'b0;
  logic cs_n = 1'b1;
  logic pc7 = 1'b0;
  logic sclk = 1'b0;
  logic run = 1'b0;
  logic wr_en = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [7:0] wdata = 8'h00;
  pld_power_pkg::mem_sel_type msel = 4'hF;
  logic [15:0] arr = 16'h0000;
  pld_power_pkg::strobe_type strobe;
  pld_power_pkg::mem_sel_type sel_out;
  pld_power_pkg::logic_bus_type bus;
  logic [15:0] addr, arr_out;
  logic [7:0] rdata, reg_a, reg_b, reg_c;
  logic sleep, code_ok, omc_en, standby;
  int miscompares = 0;
  int num_checks = 0;
  int omc_count = 0;
  pld_module_power_control uut (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .warm_reset_n_i(warm_n),
    .supply_3v3_i(supply), .chip_select_enable_i(cs_en), .chip_select_n_i(cs_n), .port_c_bit7_i(pc7),
    .shared_logic_clock_i(sclk), .strobe_i(strobe), .addr_i(addr), .data_i(8'hA5), .mem_sel_i(msel),
    .array_result_i(arr), .reg_write_i(wr_en), .reg_select_i(sel), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .power_control_reg_a_o(reg_a), .power_control_reg_b_o(reg_b), .power_control_reg_c_o(reg_c),
    .sleep_indicator_o(sleep), .code_mem_avail_o(code_ok), .mem_strobe_o(), .mem_sel_o(sel_out), .addr_o(),
    .data_o(), .logic_bus_o(bus), .omc_clock_en_o(omc_en), .array_standby_o(standby), .array_out_o(arr_out));
  host_bus_model host (.ref_clk_i(clk), .run_i(run), .turbo_off_i(reg_a[3]), .strobe_o(strobe), .addr_o(addr));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (omc_en === 1'b1) begin
      omc_count <= omc_count + 1;
    end
  end
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    sel <= s;
    wdata <= d;
    @(posedge clk) wr_en <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] exp);
    @(posedge clk) sel <= s;
    tick(2);
    check("reg_rdata_o", {8'h00, exp}, {8'h00, rdata});
  endtask
  task automatic pulse;
    @(posedge clk) run <= 1'b1;
    @(posedge clk);
    @(posedge clk) run <= 1'b0;
  endtask
  task automatic rises(input int n);
    repeat (n) begin
      @(posedge clk) sclk <= 1'b1;
      @(posedge clk);
      @(posedge clk) sclk <= 1'b0;
      @(posedge clk);
    end
    tick(4);
  endtask
  task automatic t_regs;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    wr(2'h0, 8'hFF);
    rd(2'h0, 8'h3A);
    wr(2'h1, 8'hFF);
    rd(2'h1, 8'h7C);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h00);
  endtask
  task automatic t_block;
    wr(2'h1, 8'h7C);
    wr(2'h0, 8'h30);
    @(posedge clk) pc7 <= 1'b1;
    sclk <= 1'b1;
    run <= 1'b1;
    tick(5);
    check("logic_bus_o", 16'h0070, {9'h000, bus});
    wr(2'h1, 8'h00);
    tick(3);
    check("bus port_c_bit7", 16'h0001, {15'h0000, bus.port_c_bit7});
    wr(2'h0, 8'h20);
    tick(3);
    check("bus shared_clk", 16'h0001, {15'h0000, bus.shared_clk});
    @(posedge clk) run <= 1'b0;
    sclk <= 1'b0;
    tick(3);
    omc_count = 0;
    rises(3);
    check("omc pulses", 16'h0000, omc_count[15:0]);
    wr(2'h0, 8'h00);
    omc_count = 0;
    rises(3);
    check("omc pulses", 16'h0003, omc_count[15:0]);
  endtask
  task automatic t_auto;
    wr(2'h0, 8'h02);
    pulse();
    rises(14);
    check("sleep early", 16'h0000, {15'h0000, sleep});
    rises(1);
    check("sleep", 16'h0001, {15'h0000, sleep});
    pulse();
    tick(2);
    check("sleep woken", 16'h0000, {15'h0000, sleep});
    wr(2'h0, 8'h00);
  endtask
  task automatic t_force;
    wr(2'h2, 8'h02);
    check("sleep", 16'h0001, {15'h0000, sleep});
    check("code_mem_avail_o", 16'h0000, {15'h0000, code_ok});
    wr(2'h2, 8'h00);
    check("reg_c", 16'h0002, {8'h00, reg_c});
    pulse();
    tick(2);
    check("sleep woken", 16'h0000, {15'h0000, sleep});
    wr(2'h0, 8'h0A);
    @(posedge clk) warm_n <= 1'b0;
    tick(5);
    @(posedge clk) warm_n <= 1'b1;
    tick(4);
    check("reg_c warm", 16'h0000, {8'h00, reg_c});
    check("reg_a warm", 16'h0002, {8'h00, reg_a});
    wr(2'h0, 8'h00);
  endtask
  task automatic t_cs;
    @(posedge clk) arr <= 16'h5AA5;
    tick(4);
    check("mem_sel_o", 16'h000F, {12'h000, sel_out});
    @(posedge clk) cs_en <= 1'b1;
    tick(4);
    check("mem_sel_o", 16'h0000, {12'h000, sel_out});
    check("array_out_o", 16'h5AA5, arr_out);
    @(posedge clk) cs_n <= 1'b0;
    tick(4);
    check("mem_sel_o", 16'h000F, {12'h000, sel_out});
    wr(2'h2, 8'h02);
    tick(1);
    check("mem_sel_o asleep", 16'h0000, {12'h000, sel_out});
    @(posedge clk) cs_n <= 1'b1;
    tick(4);
    @(posedge clk) cs_n <= 1'b0;
    tick(5);
    check("sleep woken", 16'h0000, {15'h0000, sleep});
    @(posedge clk) cs_en <= 1'b0;
  endtask
  task automatic t_turbo;
    int n;
    for (int s = 0; s < 2; s++) begin
      n = (s == 1) ? pld_power_pkg::IDLE_3V3_CYCLES : pld_power_pkg::IDLE_5V_CYCLES;
      @(posedge clk) supply <= (s == 1);
      wr(2'h0, 8'h08);
      pulse();
      tick(n - 3);
      check("standby early", 16'h0000, {15'h0000, standby});
      tick(7);
      check("standby", 16'h0001, {15'h0000, standby});
      @(posedge clk) arr <= arr + 16'h1111;
      tick(3);
      check("array_out_o held", arr - 16'h1111, arr_out);
      pulse();
      tick(3);
      check("standby woken", 16'h0000, {15'h0000, standby});
      check("array_out_o", arr, arr_out);
    end
    wr(2'h0, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tick(3);
    t_regs();
    t_block();
    t_auto();
    t_force();
    t_cs();
    t_turbo();
    give_verdict();
  end
  // Watchdog sized well above the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
bind pld_module_power_control pld_power_properties chk (.ref_clk_i, .rst_n_i, .clk_en_i, .warm_reset_n_i,
  .chip_select_enable_i, .chip_select_n_i, .strobe_i, .reg_write_i, .reg_select_i, .reg_wdata_i,
  .power_control_reg_a_o, .power_control_reg_b_o, .power_control_reg_c_o, .sleep_indicator_o, .code_mem_avail_o,
  .mem_strobe_o, .mem_sel_o, .addr_o, .logic_bus_o, .omc_clock_en_o, .array_standby_o, .array_out_o);
